// File: vcom_bridge_pkg.sv
package vcom_bridge_pkg;

  // clock and serial timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MIN = 9_600;
  localparam int BAUD_MAX = 921_600;
  localparam int DIV_W = 12;
  // cycles per bit: nearest for the default, bounds from the rate limits
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int RX_DEPTH = 2;

  // register bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] BAUD_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] DATA_ADDR = 4'hc;

  // field positions
  localparam int MODE_POS = 0;
  localparam int DIV_POS = 0;
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_FREE = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_ENABLE = 5;
  localparam int ST_RTS = 6;
  localparam int ST_CTS = 7;
  localparam int DATA_VALID_POS = 8;

  // handshake modes, in field order: none, outgoing, incoming, both
  typedef enum logic [1:0] {
    HS_OFF,
    HS_OUT,
    HS_IN,
    HS_BOTH
  } hs_mode_e;

  localparam hs_mode_e MODE_RESET = HS_OFF;

endpackage : vcom_bridge_pkg

// File: vcom_rx_buffer.sv
`timescale 1ns/1ps
module vcom_rx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_s;

  buf_s st_reg;
  buf_s st_next;
  logic push;
  logic pop;

  assign in_ready_out = (st_reg.cnt != FULL_CNT);
  assign out_valid_out = (st_reg.cnt != '0);
  assign out_data_out = st_reg.mem[st_reg.rp];

  always_comb begin
    st_next = st_reg;
    push = in_valid_in && in_ready_out;
    pop = out_ready_in && out_valid_out;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data_in;
      st_next.wp = (st_reg.wp == LAST_IDX) ? '0 : st_reg.wp + AW'(1);
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == LAST_IDX) ? '0 : st_reg.rp + AW'(1);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : vcom_rx_buffer

// File: vcom_target_model.sv
`timescale 1ns/1ps
module vcom_target_model (
  input wire logic clk_in,
  input wire logic txd_in,
  input wire logic cts_n_in,
  input wire logic cts_oe_in,
  output logic rxd_out,
  output logic rts_n_out,
  output logic got_out,
  output logic [7:0] byte_out,
  output logic ferr_out
);
  int div = 24;
  logic hs = 1'b0;
  logic rts_n_reg = 1'b1;
  logic [8:0] rx_sh;

  // the target always drives its request line
  assign rts_n_out = rts_n_reg;
  initial begin
    rxd_out = 1'b1;
    got_out = 1'b0;
    byte_out = 8'h00;
    ferr_out = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // undriven clear line is pulled up, so it reads as deasserted
    while (hs && (!cts_oe_in || cts_n_in)) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (div) @(posedge clk_in);
    end
  endtask : send

  // takes every character, also one begun before the request line dropped
  always begin
    @(negedge txd_in);
    repeat (div / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (div) @(posedge clk_in);
      rx_sh[i] = txd_in;
    end
    got_out <= 1'b1;
    byte_out <= rx_sh[7:0];
    ferr_out <= !rx_sh[8];
    @(posedge clk_in);
    got_out <= 1'b0;
  end
endmodule : vcom_target_model

// File: vcom_uart_flow_bridge.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module vcom_uart_flow_bridge
  import vcom_bridge_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic rts_n_in,
  output logic cts_n_out,
  output logic cts_oe_out,
  input wire logic enable_in
);

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } tx_state_e;

  typedef struct packed {
    logic rxd_s1;
    logic rxd_s2;
    logic rts_s1;
    logic rts_s2;
    logic en_s1;
    logic en_s2;
    hs_mode_e mode;
    logic [DIV_W-1:0] div;
    tx_state_e tx_state;
    logic [DIV_W-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic txd;
    logic hold_valid;
    logic [7:0] hold_data;
    logic cts_n;
    logic cts_oe;
    logic overrun;
    logic frame_err;
    logic [31:0] rdata;
  } top_s;

  top_s st_reg;
  top_s st_next;

  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready;
  logic rx_frame_err;
  logic rx_overrun;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_pop;
  logic out_fc;
  logic in_fc;
  logic rts_ok;
  logic [DIV_W-1:0] div_req;

  assign rdata_out = st_reg.rdata;
  assign txd_out = st_reg.txd;
  assign cts_n_out = st_reg.cts_n;
  assign cts_oe_out = st_reg.cts_oe;

  vcom_uart_rx u_rx (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .rxd_in(st_reg.rxd_s2),
    .div_in(st_reg.div),
    .en_in(st_reg.en_s2),
    .out_valid_out(rx_valid),
    .out_data_out(rx_data),
    .out_ready_in(rx_ready),
    .frame_err_out(rx_frame_err),
    .overrun_out(rx_overrun)
  );

  // the receiver cannot pause a character in flight, so it keeps one byte of
  // its own while the buffer is full; that covers the clear-to-send latency
  vcom_rx_buffer #(
    .WIDTH(DATA_BITS),
    .DEPTH(RX_DEPTH)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .in_valid_in(rx_valid),
    .in_data_in(rx_data),
    .in_ready_out(rx_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_pop)
  );

  always_comb begin
    st_next = st_reg;
    buf_pop = 1'b0;
    div_req = wdata_in[DIV_POS +: DIV_W];
    out_fc = (st_reg.mode == HS_OUT) || (st_reg.mode == HS_BOTH);
    in_fc = (st_reg.mode == HS_IN) || (st_reg.mode == HS_BOTH);
    // with incoming control on, an undriven request line stalls sending
    rts_ok = !in_fc || !st_reg.rts_s2;

    st_next.rxd_s1 = rxd_in;
    st_next.rxd_s2 = st_reg.rxd_s1;
    st_next.rts_s1 = rts_n_in;
    st_next.rts_s2 = st_reg.rts_s1;
    st_next.en_s1 = enable_in;
    st_next.en_s2 = st_reg.en_s1;
    st_next.rdata = '0;

    if (wr_in) begin
      case (addr_in)
        CTRL_ADDR: begin
          st_next.mode = hs_mode_e'(wdata_in[MODE_POS +: 2]);
        end
        BAUD_ADDR: begin
          // out-of-range rates clamp to the nearest supported one
          if (div_req < DIV_MIN) begin
            st_next.div = DIV_MIN;
          end else if (div_req > DIV_MAX) begin
            st_next.div = DIV_MAX;
          end else begin
            st_next.div = div_req;
          end
        end
        STATUS_ADDR: begin
          if (wdata_in[ST_OVERRUN]) begin
            st_next.overrun = 1'b0;
          end
          if (wdata_in[ST_FRAME_ERR]) begin
            st_next.frame_err = 1'b0;
          end
        end
        DATA_ADDR: begin
          // a write while the holding byte is still pending is dropped
          if (!st_reg.hold_valid) begin
            st_next.hold_valid = 1'b1;
            st_next.hold_data = wdata_in[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (rd_in) begin
      case (addr_in)
        CTRL_ADDR: begin
          st_next.rdata[MODE_POS +: 2] = st_reg.mode;
        end
        BAUD_ADDR: begin
          st_next.rdata[DIV_POS +: DIV_W] = st_reg.div;
        end
        STATUS_ADDR: begin
          st_next.rdata[ST_RX_AVAIL] = buf_valid;
          st_next.rdata[ST_TX_FREE] = !st_reg.hold_valid;
          st_next.rdata[ST_TX_BUSY] = (st_reg.tx_state != TX_IDLE);
          st_next.rdata[ST_OVERRUN] = st_reg.overrun;
          st_next.rdata[ST_FRAME_ERR] = st_reg.frame_err;
          st_next.rdata[ST_ENABLE] = st_reg.en_s2;
          st_next.rdata[ST_RTS] = !st_reg.rts_s2;
          st_next.rdata[ST_CTS] = st_reg.cts_oe && !st_reg.cts_n;
        end
        DATA_ADDR: begin
          // reading the data word pops the receive buffer
          st_next.rdata[7:0] = buf_data;
          st_next.rdata[DATA_VALID_POS] = buf_valid;
          buf_pop = buf_valid;
        end
        default: begin
        end
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (rx_overrun) begin
      st_next.overrun = 1'b1;
    end
    if (rx_frame_err) begin
      st_next.frame_err = 1'b1;
    end

    // deasserted (high) while the buffer cannot take another byte
    st_next.cts_oe = out_fc;
    st_next.cts_n = !rx_ready;

    case (st_reg.tx_state)
      TX_IDLE: begin
        st_next.txd = 1'b1;
        // request line and enable are only looked at between characters
        if (st_reg.hold_valid && st_reg.en_s2 && rts_ok) begin
          st_next.hold_valid = 1'b0;
          st_next.tx_shift = st_reg.hold_data;
          st_next.tx_state = TX_START;
          st_next.tx_cnt = st_reg.div - DIV_ONE;
          st_next.txd = 1'b0;
        end
      end
      TX_START: begin
        if (st_reg.tx_cnt != '0) begin
          st_next.tx_cnt = st_reg.tx_cnt - DIV_ONE;
        end else begin
          st_next.tx_state = TX_DATA;
          st_next.tx_cnt = st_reg.div - DIV_ONE;
          st_next.tx_bit = '0;
          st_next.txd = st_reg.tx_shift[0];
          st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
        end
      end
      TX_DATA: begin
        if (st_reg.tx_cnt != '0) begin
          st_next.tx_cnt = st_reg.tx_cnt - DIV_ONE;
        end else begin
          st_next.tx_cnt = st_reg.div - DIV_ONE;
          if (st_reg.tx_bit == LAST_BIT) begin
            st_next.tx_state = TX_STOP;
            st_next.txd = 1'b1;
          end else begin
            st_next.tx_bit = st_reg.tx_bit + 3'h1;
            st_next.txd = st_reg.tx_shift[0];
            st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
          end
        end
      end
      TX_STOP: begin
        if (st_reg.tx_cnt != '0) begin
          st_next.tx_cnt = st_reg.tx_cnt - DIV_ONE;
        end else begin
          st_next.tx_state = TX_IDLE;
        end
      end
      default: begin
        st_next.tx_state = TX_IDLE;
        st_next.txd = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= '{rxd_s1: 1'b1, rxd_s2: 1'b1, rts_s1: 1'b1, rts_s2: 1'b1,
                  en_s1: 1'b0, en_s2: 1'b0,
                  mode: MODE_RESET, div: DIV_DEFAULT,
                  tx_state: TX_IDLE, tx_cnt: '0, tx_bit: '0, tx_shift: '0,
                  txd: 1'b1, hold_valid: 1'b0, hold_data: '0,
                  cts_n: 1'b1, cts_oe: 1'b0, overrun: 1'b0, frame_err: 1'b0,
                  rdata: '0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : vcom_uart_flow_bridge

// File: vcom_uart_flow_bridge_bench.sv
`timescale 1ns/1ps
module vcom_uart_flow_bridge_bench
  import vcom_bridge_pkg::*;
();
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rd_pend = 1'b0;
  logic enable = 1'b1;
  logic [31:0] rdata;
  logic txd, rxd, rts_n, cts_n, cts_oe, got, ferr;
  logic [7:0] rx_byte;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] rb[3];
  int seed = 32'h41c5;
  int err_count = 0;
  int num_checks = 0;
  int rx_cnt = 0;
  int want = 0;

  always #25 clk = ~clk;

  vcom_uart_flow_bridge u_dut (.core_clk_in(clk), .srst_in(srst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .rxd_in(rxd), .txd_out(txd), .rts_n_in(rts_n),
    .cts_n_out(cts_n), .cts_oe_out(cts_oe), .enable_in(enable));
  vcom_target_model u_tgt (.clk_in(clk), .txd_in(txd), .cts_n_in(cts_n), .cts_oe_in(cts_oe),
    .rxd_out(rxd), .rts_n_out(rts_n), .got_out(got), .byte_out(rx_byte), .ferr_out(ferr));

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : rd

  // write then read back at once, no idle edge between
  task automatic wrd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    rd(a, m, e);
  endtask : wrd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic put(input logic [7:0] b);
    tx_q.push_back(b);
    want++;
    wr(DATA_ADDR, {24'h00_0000, b});
  endtask : put

  task automatic wait_tx();
    int k;
    k = 0;
    while (rx_cnt != want && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (rx_cnt != want) begin
      err_count++;
      $display("ERROR %0t: serial byte never arrived", $time);
      print_verdict();
    end
  endtask : wait_tx

  task automatic wait_start();
    int k;
    k = 0;
    while (txd !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (txd !== 1'b0) begin
      err_count++;
      $display("ERROR %0t: no start bit", $time);
      print_verdict();
    end
  endtask : wait_start

  always @(posedge clk) begin
    if (rd_pend) begin
      note = exp_q.pop_front();
      chk(rdata & note[63:32], note[31:0]);
    end
    rd_pend <= rd_s;
    if (got) begin
      rx_cnt++;
      if (tx_q.size() == 0) chk(32'h0000_0000, 32'h0000_0001);
      else chk(32'({ferr, rx_byte}), 32'({1'b0, tx_q.pop_front()}));
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(CTRL_ADDR, 32'h0000_0003, 32'h0000_0000);
    rd(BAUD_ADDR, 32'h0000_0fff, 32'(DIV_DEFAULT));
    rd(STATUS_ADDR, 32'h0000_0003, 32'h0000_0002);
    rd(4'h2, 32'hffff_ffff, 32'h0000_0000);
    wrd(BAUD_ADDR, 32'h0000_0000, 32'h0000_0fff, 32'(DIV_MIN));
    wrd(BAUD_ADDR, 32'h0000_0fff, 32'h0000_0fff, 32'(DIV_MAX));
    wrd(BAUD_ADDR, 32'h0000_0018, 32'h0000_0fff, 32'h0000_0018);
    // interface disabled: nothing crosses either way
    enable <= 1'b0;
    repeat (4) @(posedge clk);
    rd(STATUS_ADDR, 32'h0000_0060, 32'h0000_0000);
    put(8'($random(seed)));
    u_tgt.send(8'($random(seed)));
    repeat (300) @(posedge clk);
    chk(32'(rx_cnt), 32'(want - 1));
    rd(DATA_ADDR, 32'h0000_0100, 32'h0000_0000);
    enable <= 1'b1;
    wait_tx();
    for (int m = 0; m < 4; m++) begin
      wrd(CTRL_ADDR, 32'(m), 32'h0000_0003, 32'(m));
      repeat (3) @(posedge clk);
      chk(32'(cts_oe), 32'(m % 2));
      put(8'($random(seed)));
      if (m >= 2) begin
        repeat (300) @(posedge clk);
        chk(32'(rx_cnt), 32'(want - 1));
        u_tgt.rts_n_reg <= 1'b0;
        wait_start();
        u_tgt.rts_n_reg <= 1'b1;
      end
      wait_tx();
    end
    // outgoing throttle: third character must wait for a pop
    wr(CTRL_ADDR, 32'h0000_0001);
    u_tgt.hs = 1'b1;
    for (int i = 0; i < 3; i++) rb[i] = 8'($random(seed));
    chk(32'(cts_n), 32'h0000_0000);
    fork
      for (int i = 0; i < 3; i++) u_tgt.send(rb[i]);
    join_none
    repeat (900) @(posedge clk);
    chk(32'(cts_n), 32'h0000_0001);
    chk(32'(rxd), 32'h0000_0001);
    rd(STATUS_ADDR, 32'h0000_0083, 32'h0000_0003);
    for (int i = 0; i < 2; i++) rd(DATA_ADDR, 32'h0000_01ff, {23'h00_0000, 1'b1, rb[i]});
    repeat (400) @(posedge clk);
    rd(DATA_ADDR, 32'h0000_01ff, {23'h00_0000, 1'b1, rb[2]});
    rd(STATUS_ADDR, 32'h0000_0018, 32'h0000_0000);
    // no throttle: two bytes buffered, one held, the fourth is lost
    wr(CTRL_ADDR, 32'h0000_0000);
    u_tgt.hs = 1'b0;
    for (int i = 0; i < 4; i++) u_tgt.send(rb[i % 3]);
    // slow sender: the stop sample lands on a low data bit
    u_tgt.div = 30;
    u_tgt.send(8'h00);
    u_tgt.div = 24;
    repeat (4) @(posedge clk);
    rd(STATUS_ADDR, 32'h0000_0018, 32'h0000_0018);
    wr(STATUS_ADDR, 32'h0000_0018);
    rd(STATUS_ADDR, 32'h0000_0018, 32'h0000_0000);
    for (int i = 0; i < 3; i++) rd(DATA_ADDR, 32'h0000_01ff, {23'h00_0000, 1'b1, rb[i]});
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : vcom_uart_flow_bridge_bench

bind vcom_uart_flow_bridge vcom_uart_flow_bridge_monitor u_mon (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd_in), .txd_out(txd_out), .rts_n_in(rts_n_in),
  .cts_n_out(cts_n_out), .cts_oe_out(cts_oe_out), .enable_in(enable_in));

// File: vcom_uart_flow_bridge_monitor.sv
`timescale 1ns/1ps
module vcom_uart_flow_bridge_monitor
  import vcom_bridge_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic rxd_in,
  input wire logic txd_out,
  input wire logic rts_n_in,
  input wire logic cts_n_out,
  input wire logic cts_oe_out,
  input wire logic enable_in
);
  logic [1:0] mode_reg;
  logic [1:0] age_reg;
  logic [2:0] up_reg;
  logic [1:0] pop_reg;

  // cts lags a pop by two edges and a mode write by two as well
  always_ff @(posedge core_clk_in) begin
    pop_reg <= {pop_reg[0], rd_in && addr_in == DATA_ADDR};
    if (srst_in) begin
      mode_reg <= 2'h0;
      age_reg <= 2'h3;
      up_reg <= 3'h0;
    end else begin
      if (wr_in && addr_in == CTRL_ADDR) begin
        mode_reg <= wdata_in[1:0];
        age_reg <= 2'h0;
      end else if (age_reg != 2'h3) begin
        age_reg <= age_reg + 2'h1;
      end
      if (up_reg != 3'h7) begin
        up_reg <= up_reg + 3'h1;
      end
    end
  end

  function automatic logic [11:0] clamp(input logic [11:0] d);
    if (d < DIV_MIN) return DIV_MIN;
    if (d > DIV_MAX) return DIV_MAX;
    return d;
  endfunction : clamp

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence wr_to(logic [3:0] a); wr_in && addr_in == a; endsequence
  sequence rd_at(logic [3:0] a); rd_in && addr_in == a; endsequence
  // sync flops need a few quiet edges before status can follow the pins
  sequence en_steady; $stable(enable_in) [*4]; endsequence
  sequence rts_steady; $stable(rts_n_in) [*4]; endsequence

  a_reset_lines: assert property ($fell(srst_in) |-> txd_out && cts_n_out && !cts_oe_out && rdata_out == 32'h0)
    else $error("outputs not at reset level");
  a_rdata_quiet: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data outside a read answer");
  a_unmapped_zero: assert property (rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (wr_to(CTRL_ADDR) ##1 rd_at(CTRL_ADDR) |=> rdata_out[1:0] == $past(wdata_in[1:0], 2))
    else $error("mode readback wrong");
  a_baud_clamp: assert property (wr_to(BAUD_ADDR) ##1 rd_at(BAUD_ADDR) |=> rdata_out[11:0] == clamp($past(wdata_in[11:0], 2)))
    else $error("bit divisor not clamped");
  a_oe_by_mode: assert property (age_reg == 2'h3 |-> cts_oe_out == mode_reg[0])
    else $error("clear line drive does not follow mode");
  a_cts_holds: assert property ($past(cts_oe_out && cts_n_out) && pop_reg == 2'h0 |-> cts_n_out || !cts_oe_out)
    else $error("clear line released without a pop");
  a_enable_status: assert property (en_steady ##0 rd_at(STATUS_ADDR) ##0 up_reg == 3'h7 |=> rdata_out[ST_ENABLE] == $past(enable_in))
    else $error("enable status wrong");
  a_rts_status: assert property (rts_steady ##0 rd_at(STATUS_ADDR) ##0 up_reg == 3'h7 |=> rdata_out[ST_RTS] == !$past(rts_n_in))
    else $error("request status wrong");
endmodule : vcom_uart_flow_bridge_monitor

// File: vcom_uart_rx.sv
`timescale 1ns/1ps
module vcom_uart_rx
  import vcom_bridge_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic rxd_in,
  input wire logic [DIV_W-1:0] div_in,
  input wire logic en_in,
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in,
  output logic frame_err_out,
  output logic overrun_out
);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    rx_state_e state;
    logic prev;
    logic [DIV_W-1:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic valid;
    logic [7:0] data;
    logic frame_err;
    logic overrun;
  } rx_s;

  rx_s st_reg;
  rx_s st_next;

  assign out_valid_out = st_reg.valid;
  assign out_data_out = st_reg.data;
  assign frame_err_out = st_reg.frame_err;
  assign overrun_out = st_reg.overrun;

  always_comb begin
    st_next = st_reg;
    st_next.prev = rxd_in;
    st_next.frame_err = 1'b0;
    st_next.overrun = 1'b0;
    if (st_reg.valid && out_ready_in) begin
      st_next.valid = 1'b0;
    end
    case (st_reg.state)
      RX_IDLE: begin
        if (st_reg.prev && !rxd_in) begin
          st_next.state = RX_START;
          st_next.cnt = {1'b0, div_in[DIV_W-1:1]};
        end
      end
      RX_START: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - DIV_ONE;
        end else if (rxd_in) begin
          // start bit gone at mid-bit: a glitch, not a character
          st_next.state = RX_IDLE;
        end else begin
          st_next.state = RX_DATA;
          st_next.cnt = div_in - DIV_ONE;
          st_next.bit_idx = '0;
        end
      end
      RX_DATA: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - DIV_ONE;
        end else begin
          st_next.shift = {rxd_in, st_reg.shift[7:1]};
          st_next.cnt = div_in - DIV_ONE;
          st_next.bit_idx = st_reg.bit_idx + 3'h1;
          if (st_reg.bit_idx == LAST_BIT) begin
            st_next.state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - DIV_ONE;
        end else begin
          st_next.state = RX_IDLE;
          if (!rxd_in) begin
            st_next.frame_err = 1'b1;
          end else if (en_in) begin
            if (st_next.valid) begin
              st_next.overrun = 1'b1;
            end else begin
              st_next.valid = 1'b1;
              st_next.data = st_reg.shift;
            end
          end
        end
      end
      default: begin
        st_next.state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= '{state: RX_IDLE, prev: 1'b1, cnt: '0, bit_idx: '0, shift: '0,
                  valid: 1'b0, data: '0, frame_err: 1'b0, overrun: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : vcom_uart_rx
